// ===== rtl/dss_pkg.sv
// package: constants, types and helpers for the daylight-saving scheduler
package dss_pkg;

  localparam logic [7:0] DSS_START_MONTH_OFS = 8'h20;
  localparam logic [7:0] DSS_START_DW_OFS    = 8'h21;
  localparam logic [7:0] DSS_START_DATE_OFS  = 8'h22;
  localparam logic [7:0] DSS_START_HOUR_OFS  = 8'h23;
  localparam logic [7:0] DSS_END_MONTH_OFS   = 8'h24;
  localparam logic [7:0] DSS_END_DW_OFS      = 8'h25;
  localparam logic [7:0] DSS_END_DATE_OFS    = 8'h26;
  localparam logic [7:0] DSS_END_HOUR_OFS    = 8'h27;

  localparam logic [7:0] DSS_START_MONTH_RST = 8'h00;
  localparam logic [7:0] DSS_START_DW_RST    = 8'h00;
  localparam logic [7:0] DSS_START_DATE_RST  = 8'h00;
  localparam logic [7:0] DSS_START_HOUR_RST  = 8'h00;
  localparam logic [7:0] DSS_END_MONTH_RST   = 8'h10;
  localparam logic [7:0] DSS_END_DW_RST      = 8'h00;
  localparam logic [7:0] DSS_END_DATE_RST    = 8'h00;
  localparam logic [7:0] DSS_END_HOUR_RST    = 8'h00;

  // writable bit masks; other bits read as zero
  localparam logic [7:0] DSS_START_MONTH_MASK = 8'h9F;
  localparam logic [7:0] DSS_END_MONTH_MASK   = 8'h1F;
  localparam logic [7:0] DSS_DW_MASK          = 8'h7F;
  localparam logic [7:0] DSS_DATE_MASK        = 8'h3F;
  localparam logic [7:0] DSS_HOUR_MASK        = 8'h3F;

  localparam int         DSS_ENABLE_BIT   = 7;
  localparam int         DSS_PRIO_BIT     = 6;
  localparam int         DSS_WEEK_LSB     = 3;
  localparam int         DSS_DOW_LSB      = 0;
  localparam logic [2:0] DSS_LAST_WEEK    = 3'h7;
  localparam logic [2:0] DSS_DAYS_IN_WEEK = 3'h7;
  localparam logic [7:0] DSS_FEB_BCD      = 8'h02;

  // running calendar, all fields in clock-register bcd format
  typedef struct packed {
    logic [7:0] year;
    logic [4:0] month;
    logic [5:0] date;
    logic [2:0] dow;
    logic [5:0] hour;
    logic [6:0] minute;
    logic [6:0] second;
  } dss_cal_t;

  // one schedule: month, day/week, date, hour bytes
  typedef struct packed {
    logic [7:0] month;
    logic [7:0] day_week;
    logic [7:0] date;
    logic [7:0] hour;
  } dss_sched_t;

  function automatic logic [6:0] dss_bcd2bin(input logic [7:0] bcd);
    logic [6:0] tens;
    tens = {3'h0, bcd[7:4]};
    return 7'((tens << 3) + (tens << 1) + {3'h0, bcd[3:0]});
  endfunction : dss_bcd2bin

  function automatic logic [6:0] dss_days_in_month(input logic [7:0] month_bcd,
                                                    input logic [7:0] year_bcd);
    logic [6:0] m;
    logic [6:0] y;
    m = dss_bcd2bin(month_bcd);
    y = dss_bcd2bin(year_bcd);
    if (m == 7'h02)
      return (y[1:0] == 2'h0) ? 7'h1D : 7'h1C;
    else if (m == 7'h04 || m == 7'h06 || m == 7'h09 || m == 7'h0B)
      return 7'h1E;
    else
      return 7'h1F;
  endfunction : dss_days_in_month

endpackage : dss_pkg

// ===== rtl/dss_sched_match.sv
// schedule comparator: one schedule against the running calendar
`timescale 1ns/100ps
module dss_sched_match (
  input  wire dss_pkg::dss_sched_t sched_in,
  input  wire dss_pkg::dss_cal_t   cal_in,
  output logic                     day_hour_match_out
);
  import dss_pkg::*;

  logic [6:0] date_bin;
  logic [6:0] month_days;
  logic [2:0] week_now;
  logic       last_week;
  logic [2:0] want_week;
  logic [2:0] want_dow;
  logic       week_day_ok;
  logic       date_ok;
  logic       day_ok;
  logic       month_ok;
  logic       hour_ok;

  always_comb begin
    date_bin   = dss_bcd2bin({2'h0, cal_in.date});
    month_days = dss_days_in_month({3'h0, cal_in.month}, cal_in.year);
    week_now   = 3'(((date_bin - 7'h01) / 7'(DSS_DAYS_IN_WEEK)) + 7'h01);
    last_week  = (date_bin + 7'(DSS_DAYS_IN_WEEK)) > month_days;
    want_week  = sched_in.day_week[DSS_WEEK_LSB +: 3];
    want_dow   = sched_in.day_week[DSS_DOW_LSB +: 3];
    week_day_ok = ((want_week == DSS_LAST_WEEK) ? last_week : (want_week == week_now))
                  && (want_dow == cal_in.dow);
    date_ok  = (sched_in.date[5:0] == cal_in.date);
    day_ok   = sched_in.day_week[DSS_PRIO_BIT] ? week_day_ok : date_ok;
    month_ok = (sched_in.month[4:0] == cal_in.month);
    hour_ok  = (sched_in.hour[5:0] == cal_in.hour);
    day_hour_match_out = month_ok && day_ok && hour_ok;
  end

endmodule : dss_sched_match

// ===== rtl/dss_scheduler.sv
// daylight-saving scheduler: schedule bytes, matching and hour adjustment
// Summary of operation
// - enable bit is bit 7 of byte 20h; adjustment only while it is one.
// - every reset clears the enable bit.
// - writing the enable bit to zero clears the adjusted flag.
// - start schedule at 20h-23h, end schedule at 24h-27h.
// - start month uses calendar month coding, resets to 00h.
// - end month uses calendar month coding, resets to 10h.
// - day/week bits 0-2 hold the target weekday, 0 to 6.
// - day/week bits 3-5 hold week 1 to 5; 7 means last week.
// - start byte 21h bit 6 set gives week and weekday priority.
// - end byte 25h bit 6 set gives week and weekday priority.
// - start date compared only when the start priority bit is zero.
// - end date compared only when the end priority bit is zero.
// - hour fields lack the mode bit, compared in current hour mode.
`timescale 1ns/100ps
module dss_scheduler (
  input  wire logic             ref_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [7:0]       reg_addr_in,
  input  wire logic [7:0]       reg_wdata_in,
  input  wire logic             reg_wr_in,
  input  wire logic             reg_rd_in,
  output logic [7:0]            reg_rdata_out,
  input  wire dss_pkg::dss_cal_t cal_in,
  input  wire logic             cal_update_in,
  output logic                  hour_advance_out,
  output logic                  hour_retard_out,
  output logic                  saving_enable_out,
  output logic                  saving_adjusted_flag_out
);
  import dss_pkg::*;

  logic [7:0] start_month_q;
  logic [7:0] start_dw_q;
  logic [7:0] start_date_q;
  logic [7:0] start_hour_q;
  logic [7:0] end_month_q;
  logic [7:0] end_dw_q;
  logic [7:0] end_date_q;
  logic [7:0] end_hour_q;
  logic       flag_q;
  logic       advance_q;
  logic       retard_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  dss_sched_t start_sched;
  dss_sched_t end_sched;
  logic       start_match;
  logic       end_match;
  logic       hour_edge;
  logic       fire_start;
  logic       fire_end;
  logic       enable_off_wr;

  function automatic logic wr_hit(input logic [7:0] ofs);
    return reg_wr_in && (reg_addr_in == ofs);
  endfunction : wr_hit

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_month_q <= DSS_START_MONTH_RST;
      start_dw_q    <= DSS_START_DW_RST;
      start_date_q  <= DSS_START_DATE_RST;
      start_hour_q  <= DSS_START_HOUR_RST;
    end else begin
      if (wr_hit(DSS_START_MONTH_OFS)) begin
        start_month_q <= reg_wdata_in & DSS_START_MONTH_MASK;
      end
      if (wr_hit(DSS_START_DW_OFS)) begin
        start_dw_q <= reg_wdata_in & DSS_DW_MASK;
      end
      if (wr_hit(DSS_START_DATE_OFS)) begin
        start_date_q <= reg_wdata_in & DSS_DATE_MASK;
      end
      if (wr_hit(DSS_START_HOUR_OFS)) begin
        start_hour_q <= reg_wdata_in & DSS_HOUR_MASK;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      end_month_q <= DSS_END_MONTH_RST;
      end_dw_q    <= DSS_END_DW_RST;
      end_date_q  <= DSS_END_DATE_RST;
      end_hour_q  <= DSS_END_HOUR_RST;
    end else begin
      if (wr_hit(DSS_END_MONTH_OFS)) begin
        end_month_q <= reg_wdata_in & DSS_END_MONTH_MASK;
      end
      if (wr_hit(DSS_END_DW_OFS)) begin
        end_dw_q <= reg_wdata_in & DSS_DW_MASK;
      end
      if (wr_hit(DSS_END_DATE_OFS)) begin
        end_date_q <= reg_wdata_in & DSS_DATE_MASK;
      end
      if (wr_hit(DSS_END_HOUR_OFS)) begin
        end_hour_q <= reg_wdata_in & DSS_HOUR_MASK;
      end
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    unique case (reg_addr_in)
      DSS_START_MONTH_OFS: rdata_d = start_month_q;
      DSS_START_DW_OFS:    rdata_d = start_dw_q;
      DSS_START_DATE_OFS:  rdata_d = start_date_q;
      DSS_START_HOUR_OFS:  rdata_d = start_hour_q;
      DSS_END_MONTH_OFS:   rdata_d = end_month_q;
      DSS_END_DW_OFS:      rdata_d = end_dw_q;
      DSS_END_DATE_OFS:    rdata_d = end_date_q;
      DSS_END_HOUR_OFS:    rdata_d = end_hour_q;
      default:             rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_in) begin
      rdata_q <= rdata_d;
    end
  end

  assign start_sched = '{month: start_month_q, day_week: start_dw_q,
                         date: start_date_q, hour: start_hour_q};
  assign end_sched   = '{month: end_month_q, day_week: end_dw_q,
                         date: end_date_q, hour: end_hour_q};

  dss_sched_match u_start_match (
    .sched_in           (start_sched),
    .cal_in             (cal_in),
    .day_hour_match_out (start_match)
  );

  dss_sched_match u_end_match (
    .sched_in           (end_sched),
    .cal_in             (cal_in),
    .day_hour_match_out (end_match)
  );

  // act only on the first second of the scheduled hour
  assign hour_edge = cal_update_in && (cal_in.minute == 7'h00) && (cal_in.second == 7'h00);
  assign fire_start = hour_edge && start_month_q[DSS_ENABLE_BIT] && start_match && !flag_q;
  // end fires once, only while adjusted
  assign fire_end   = hour_edge && start_month_q[DSS_ENABLE_BIT] && end_match && flag_q;
  assign enable_off_wr = wr_hit(DSS_START_MONTH_OFS) && !reg_wdata_in[DSS_ENABLE_BIT];

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_q <= 1'b0;
    end else if (enable_off_wr) begin
      flag_q <= 1'b0;
    end else if (fire_start) begin
      flag_q <= 1'b1;
    end else if (fire_end) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      advance_q <= 1'b0;
      retard_q  <= 1'b0;
    end else begin
      advance_q <= fire_start && !enable_off_wr;
      retard_q  <= fire_end && !enable_off_wr;
    end
  end

  assign reg_rdata_out            = rdata_q;
  assign hour_advance_out         = advance_q;
  assign hour_retard_out          = retard_q;
  assign saving_enable_out        = start_month_q[DSS_ENABLE_BIT];
  assign saving_adjusted_flag_out = flag_q;

endmodule : dss_scheduler

// ===== test/dss_scheduler_assertions.sv
// checker: port-level properties of the daylight-saving scheduler
`timescale 1ns/100ps
module dss_scheduler_assertions (
  input wire logic              ref_clk_in,
  input wire logic              rst_n_in,
  input wire logic [7:0]        reg_addr_in,
  input wire logic [7:0]        reg_wdata_in,
  input wire logic              reg_wr_in,
  input wire logic              reg_rd_in,
  input wire logic [7:0]        reg_rdata_out,
  input wire dss_pkg::dss_cal_t cal_in,
  input wire logic              cal_update_in,
  input wire logic              hour_advance_out,
  input wire logic              hour_retard_out,
  input wire logic              saving_enable_out,
  input wire logic              saving_adjusted_flag_out
);
  import dss_pkg::*;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_adv_needs_enable: assert property (hour_advance_out |-> $past(saving_enable_out))
    else $error("advance without enable");
  a_adv_sets_flag: assert property (hour_advance_out |-> saving_adjusted_flag_out)
    else $error("advance without flag");
  a_ret_clears_flag: assert property (hour_retard_out |->
    $past(saving_adjusted_flag_out) && !saving_adjusted_flag_out) else $error("bad retard");
  a_adv_on_boundary: assert property (hour_advance_out |-> $past(cal_update_in) &&
    $past(cal_in.minute) == 7'h00 && $past(cal_in.second) == 7'h00) else $error("bad advance");
  a_flag_rise_cause: assert property ($rose(saving_adjusted_flag_out) |-> hour_advance_out)
    else $error("flag rose alone");
  a_disable_clears: assert property (reg_wr_in && reg_addr_in == 8'h20 && !reg_wdata_in[7] |=>
    !saving_adjusted_flag_out && !saving_enable_out && !hour_advance_out) else $error("no clear");
  a_enable_copy: assert property (reg_wr_in && reg_addr_in == 8'h20 |=>
    saving_enable_out == $past(reg_wdata_in[7])) else $error("enable not written");
  a_unmapped_read: assert property (reg_rd_in && (reg_addr_in < 8'h20 || reg_addr_in > 8'h27)
    |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data moved");
  a_zero_bits: assert property (reg_rd_in && reg_addr_in inside {8'h22, 8'h23, 8'h26, 8'h27}
    |=> reg_rdata_out[7:6] == 2'h0) else $error("zero bits set");
  a_pulse_single: assert property (hour_advance_out || hour_retard_out |=>
    !hour_advance_out && !hour_retard_out) else $error("pulse too long");
  c_advance: cover property (hour_advance_out);
  c_retard: cover property (hour_retard_out);
  c_disable_flag: cover property (saving_adjusted_flag_out ##1 !saving_enable_out);
endmodule : dss_scheduler_assertions
bind dss_scheduler dss_scheduler_assertions u_dss_scheduler_assertions (.*);

// ===== test/dss_cal_model.sv
// calendar model: holds the running calendar and applies hour requests
`timescale 1ns/100ps
module dss_cal_model (
  input  wire logic              ref_clk_in,
  input  wire logic              load_in,
  input  wire dss_pkg::dss_cal_t load_cal_in,
  input  wire logic              hour_advance_in,
  input  wire logic              hour_retard_in,
  output dss_pkg::dss_cal_t      cal_out
);
  import dss_pkg::*;
  always_ff @(posedge ref_clk_in) begin
    if (load_in) cal_out <= load_cal_in;
    else if (hour_advance_in) cal_out.hour <= cal_out.hour + 6'h01;
    else if (hour_retard_in) cal_out.hour <= cal_out.hour - 6'h01;
  end
endmodule : dss_cal_model

// ===== test/dss_scheduler_test.sv
// testbench: registers, schedule matching and hour adjustment
`timescale 1ns/100ps
module dss_scheduler_test;
  import dss_pkg::*;
  logic ref_clk_in, rst_n_in, wr, rd, upd, ld, adv, ret, en, flag;
  logic [7:0] addr, wdata, rdata, v, d;
  dss_cal_t cal, lc;
  int n_errors, samples_checked;
  dss_scheduler u_dss_scheduler (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .cal_in(cal), .cal_update_in(upd), .hour_advance_out(adv),
    .hour_retard_out(ret), .saving_enable_out(en), .saving_adjusted_flag_out(flag));
  dss_cal_model u_dss_cal_model (.ref_clk_in(ref_clk_in), .load_in(ld), .load_cal_in(lc),
    .hour_advance_in(adv), .hour_retard_in(ret), .cal_out(cal));
  function automatic logic [7:0] exp_mask(input logic [7:0] a);
    case (a)
      8'h20: return DSS_START_MONTH_MASK;
      8'h24: return DSS_END_MONTH_MASK;
      8'h21, 8'h25: return DSS_DW_MASK;
      default: return DSS_DATE_MASK;
    endcase
  endfunction : exp_mask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] dv);
    @(posedge ref_clk_in) #1;
    addr = a;
    wdata = dv;
    wr = 1'b1;
    @(posedge ref_clk_in) #1;
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] dv);
    @(posedge ref_clk_in) #1;
    addr = a;
    rd = 1'b1;
    @(posedge ref_clk_in) #1;
    rd = 1'b0;
    dv = rdata;
  endtask : rd_reg
  // load a calendar at hh:00:00, raise the update, check the request pair and new hour
  task automatic fire(input logic [4:0] m, input logic [5:0] dt, input logic [2:0] w,
                      input logic [5:0] h, input logic [1:0] e);
    @(posedge ref_clk_in) #1;
    lc = '0;
    lc.year = 8'h24;
    lc.month = m;
    lc.date = dt;
    lc.dow = w;
    lc.hour = h;
    ld = 1'b1;
    @(posedge ref_clk_in) #1;
    ld = 1'b0;
    upd = 1'b1;
    @(posedge ref_clk_in) #1;
    upd = 1'b0;
    chk({6'h0, adv, ret}, {6'h0, e});
    @(posedge ref_clk_in) #1;
    chk({2'h0, cal.hour}, {2'h0, h + {5'h0, e[1]} - {5'h0, e[0]}});
  endtask : fire
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    #(50 * 20000);
    n_errors++;
    report_and_stop();
  end
  initial begin
    rst_n_in = 1'b0;
    {wr, rd, upd, addr, wdata} = '0;
    ld = 1'b1;
    lc = '0;
    n_errors = 0;
    samples_checked = 0;
    void'($urandom(50623));
    repeat (16) @(posedge ref_clk_in);
    #1 rst_n_in = 1'b1;
    for (int a = 8'h20; a <= 8'h27; a++) begin
      rd_reg(8'(a), v);
      chk(v, (a == 8'h24) ? 8'h10 : 8'h00);
    end
    chk({7'h0, en}, 8'h00);
    repeat (4) begin
      for (int a = 8'h20; a <= 8'h27; a++) begin
        d = 8'($urandom);
        wr_reg(8'(a), d);
        if (a == 8'h20) chk({7'h0, en}, {7'h0, d[7]});
        rd_reg(8'(a), v);
        chk(v, d & exp_mask(8'(a)));
      end
      d = 8'($urandom_range(8'h28, 8'hFF));
      wr_reg(d, 8'hFF);
      rd_reg(d, v);
      chk(v, 8'h00);
    end
    wr_reg(8'h20, 8'h03);
    wr_reg(8'h21, 8'h05);
    wr_reg(8'h22, 8'h10);
    wr_reg(8'h23, 8'h02);
    fire(5'h03, 6'h10, 3'h0, 6'h02, 2'b00);
    wr_reg(8'h20, 8'h83);
    fire(5'h03, 6'h11, 3'h0, 6'h02, 2'b00);
    fire(5'h03, 6'h10, 3'h0, 6'h02, 2'b10);
    chk({7'h0, flag}, 8'h01);
    fire(5'h03, 6'h10, 3'h0, 6'h02, 2'b00);
    wr_reg(8'h24, 8'h10);
    wr_reg(8'h25, 8'h78);
    wr_reg(8'h26, 8'h05);
    wr_reg(8'h27, 8'h02);
    fire(5'h10, 6'h20, 3'h0, 6'h02, 2'b00);
    fire(5'h10, 6'h27, 3'h0, 6'h02, 2'b01);
    chk({7'h0, flag}, 8'h00);
    fire(5'h10, 6'h27, 3'h0, 6'h02, 2'b00);
    wr_reg(8'h21, 8'h53);
    wr_reg(8'h22, 8'h01);
    fire(5'h03, 6'h10, 3'h3, 6'h12, 2'b00);
    fire(5'h03, 6'h10, 3'h2, 6'h02, 2'b00);
    fire(5'h03, 6'h10, 3'h3, 6'h02, 2'b10);
    // end schedule by date: week and weekday alone must not match
    wr_reg(8'h25, 8'h38);
    fire(5'h10, 6'h27, 3'h0, 6'h02, 2'b00);
    fire(5'h10, 6'h05, 3'h4, 6'h02, 2'b01);
    // last week of a leap-year february, 29 days
    wr_reg(8'h24, 8'h02);
    wr_reg(8'h25, 8'h7E);
    fire(5'h03, 6'h10, 3'h3, 6'h02, 2'b10);
    fire(5'h02, 6'h22, 3'h6, 6'h02, 2'b00);
    fire(5'h02, 6'h23, 3'h6, 6'h02, 2'b01);
    fire(5'h03, 6'h10, 3'h3, 6'h02, 2'b10);
    chk({7'h0, flag}, 8'h01);
    wr_reg(8'h20, 8'h03);
    chk({6'h0, en, flag}, 8'h00);
    // mid-run reset with the enable set
    wr_reg(8'h20, 8'h83);
    chk({7'h0, en}, 8'h01);
    @(posedge ref_clk_in) #1;
    rst_n_in = 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1 rst_n_in = 1'b1;
    chk({6'h0, en, flag}, 8'h00);
    rd_reg(8'h24, v);
    chk(v, 8'h10);
    report_and_stop();
  end
endmodule : dss_scheduler_test
